// file: dv/rtcal_core_tb.sv
`timescale 1ns/1ps
module rtcal_core_tb;
	localparam int         XT  = 8192;
	localparam logic [6:0] ADR = 7'h32;
	logic        clk;
	logic        clk_xtal;
	logic        rstn;
	logic        ce;
	logic [7:0]  sec0;
	logic        scl;
	logic        sda_low;
	logic        sda;
	logic        sda_oe;
	logic        wk_oe;
	logic        dy_oe;
	logic [2:0]  od;
	logic [63:0] r;
	logic [7:0]  bq;
	logic        ba;
	int          miscompares;
	int          samples_checked;
	// offset, written, read back
	logic [23:0] rows [10] = '{24'h01FF_7F, 24'h02FF_3F, 24'h03FF_07, 24'h04FF_3F, 24'h05FF_9F,
		24'h0699_99, 24'h07FF_7F, 24'h0DFF_00, 24'h0E3F_3F, 24'h0FFF_FC};

	// pull-up on the data wire
	assign sda = !(sda_oe || sda_low);
	////////////////////////////////////////////////////////////////
	rtcal_core #(.SLV_ADDR(ADR), .XT_HZ(XT), .ADJ_SECS(10)) dut (
		.clk                  (clk),
		.clk_xtal             (clk_xtal),
		.rstn                 (rstn),
		.ce                   (ce),
		.scl_i                (scl),
		.sda_i                (sda),
		.sda_o                (od[2]),
		.sda_oe               (sda_oe),
		.weekly_alarm_irq_n   (od[1]),
		.weekly_alarm_irq_n_oe(wk_oe),
		.daily_alarm_irq_n    (od[0]),
		.daily_alarm_irq_n_oe (dy_oe)
	);
	rtcal_host host (
		.clk    (clk),
		.sda    (sda),
		.scl    (scl),
		.sda_low(sda_low)
	);
	////////////////////////////////////////////////////////////////
	always #50 clk = ~clk;
	initial begin
		clk_xtal = 1'b0;
		#17;
		forever #32 clk_xtal = ~clk_xtal;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// first byte in the top of the n-byte field
	task automatic wr(input logic [3:0] p, input int n, input logic [63:0] d);
		logic [7:0] q;
		logic       a;
		host.start();
		host.xfer({ADR, 1'b0}, 1'b1, q, a);
		chk(32'(a), 32'h0);
		host.xfer({4'h0, p}, 1'b1, q, a);
		for (int i = n - 1; i >= 0; i--) begin
			host.xfer(d[8*i +: 8], 1'b1, q, a);
			chk(32'(a), 32'h0);
		end
		host.stop();
	endtask : wr

	task automatic rd(input logic [3:0] p, input int n, output logic [63:0] v);
		logic [7:0] q;
		logic       a;
		v = '0;
		wr(p, 0, 64'h0);
		host.start();
		host.xfer({ADR, 1'b1}, 1'b1, q, a);
		for (int i = n - 1; i >= 0; i--) begin
			host.xfer(8'hFF, i == 0, q, a);
			v[8*i +: 8] = q;
		end
		host.stop();
	endtask : rd

	// alarms at 00:00, calendar at 23:59:59, then one second
	task automatic roll(input logic [7:0] wd, dy, mo, yr, ctl, msk, input logic [31:0] e, input logic [1:0] fl);
		wr(4'h8, 7, {24'h0, msk, 24'h0, ctl});
		wr(4'h1, 6, {16'h0, 16'h5923, wd, dy, mo, yr});
		// seconds last, so a tick mid-write cannot carry into a stale minute
		wr(4'h0, 1, 64'h59);
		repeat (XT * 64 * 12 / 1000) @(posedge clk);
		chk(32'({wk_oe, dy_oe}), 32'(fl));
		rd(4'h3, 4, r);
		chk(r[31:0], e);
		rd(4'hF, 1, r);
		chk(32'(r[1:0]), 32'(fl));
		wr(4'hF, 1, 64'h0);
		chk(32'({wk_oe, dy_oe}), 32'h0);
		$display("test rollover done");
	endtask : roll

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////
	initial begin
		clk             = 1'b0;
		rstn            = 1'b0;
		ce              = 1'b1;
		miscompares     = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk);
		chk(32'(od), 32'h0);
		chk(32'({sda_oe, wk_oe, dy_oe}), 32'h0);
		rstn <= 1'b1;
		repeat (5) @(posedge clk);
		rd(4'h3, 4, r);
		chk(r[31:0], 32'h0001_0100);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i][19:16], 1, {56'h0, rows[i][15:8]});
			rd(rows[i][19:16], 1, r);
			chk(r[31:0], 32'(rows[i][7:0]));
		end
		$display("test register table done");
		host.start();
		host.xfer({ADR ^ 7'h01, 1'b0}, 1'b1, bq, ba);
		host.stop();
		chk(32'(ba), 32'h1);
		$display("test foreign address done");
		// frozen core must not count: over three seconds pass, at most two ticks may land
		rd(4'h0, 1, r);
		sec0 = 8'(r[7:4] * 8'h0A + r[3:0]);
		ce <= 1'b0;
		repeat (16000) @(posedge clk);
		ce <= 1'b1;
		rd(4'h0, 1, r);
		chk(32'(8'(r[7:4] * 8'h0A + r[3:0]) - sec0 <= 8'h02), 32'h1);
		$display("test clock enable done");
		roll(8'h06, 8'h28, 8'h02, 8'h04, 8'hC0, 8'h01, 32'h0029_0204, 2'b11);
		roll(8'h01, 8'h28, 8'h82, 8'h01, 8'hC0, 8'h01, 32'h0201_8301, 2'b01);
		roll(8'h02, 8'h28, 8'h82, 8'h00, 8'h00, 8'hFF, 32'h0329_8200, 2'b00);
		roll(8'h03, 8'h28, 8'h02, 8'h00, 8'h40, 8'hFF, 32'h0401_0300, 2'b01);
		roll(8'h04, 8'h31, 8'h12, 8'h99, 8'h80, 8'h20, 32'h0501_8100, 2'b10);
		// reset mid-run: century, calendar and correction word back to defaults
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'({sda_oe, wk_oe, dy_oe}), 32'h0);
		rstn <= 1'b1;
		repeat (5) @(posedge clk);
		rd(4'h4, 4, r);
		chk(r[31:0], 32'h0101_0000);
		$display("test reset mid-run done");
		end_of_test();
	end

	// run needs about 84k cycles; cut off well past that
	initial begin
		#(97_000 * 100);
		miscompares++;
		end_of_test();
	end
endmodule : rtcal_core_tb

// file: dv/rtcal_host.sv
`timescale 1ns/1ps
module rtcal_host #(
	parameter int HALF = 6
) (
	// bench clock
	input  wire logic clk,
	// resolved data wire
	input  wire logic sda,
	// bus clock and data pull-down
	output logic      scl,
	output logic      sda_low
);
	////////////////////////////////////////////////////////////////
	initial begin
		scl     = 1'b1;
		sda_low = 1'b0;
	end

	task automatic half();
		repeat (HALF) @(posedge clk);
	endtask : half

	// data moves two cycles after the fall, so the device never sees it with scl high
	task automatic bit_x(input logic b, output logic r);
		repeat (2) @(posedge clk);
		sda_low <= !b;
		half();
		scl <= 1'b1;
		half();
		r = sda;
		scl <= 1'b0;
	endtask : bit_x

	// msb first, ninth slot is the acknowledge
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
		bit_x(ak, a);
	endtask : xfer

	task automatic start();
		repeat (2) @(posedge clk);
		sda_low <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b1;
		half();
		scl <= 1'b0;
	endtask : start

	task automatic stop();
		repeat (2) @(posedge clk);
		sda_low <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sda_low <= 1'b0;
		half();
	endtask : stop
endmodule : rtcal_host

// file: verilog/rtcal_cfg.svh
`ifndef RTCAL_CFG_SVH
`define RTCAL_CFG_SVH

// register offsets
`define RTCAL_SEC 4'h0
`define RTCAL_MIN 4'h1
`define RTCAL_HR 4'h2
`define RTCAL_WDAY 4'h3
`define RTCAL_DAY 4'h4
`define RTCAL_MON 4'h5
`define RTCAL_YR 4'h6
`define RTCAL_ADJ 4'h7
`define RTCAL_WMIN 4'h8
`define RTCAL_WHR 4'h9
`define RTCAL_WWD 4'hA
`define RTCAL_DMIN 4'hB
`define RTCAL_DHR 4'hC
`define RTCAL_CTL1 4'hE
`define RTCAL_CTL2 4'hF
// field positions
`define RTCAL_WEN 7
`define RTCAL_DEN 6
`define RTCAL_WFLG 1
`define RTCAL_DFLG 0
`define RTCAL_CEN 7
`define RTCAL_ADJ_DIR 6
// reset values and timing
`define RTCAL_RST_DATE 8'h01
`define RTCAL_XT_HZ 32768
`define RTCAL_ADJ_SECS 10
`define RTCAL_ADDR 7'h32
`endif

// file: verilog/rtcal_core.sv
`timescale 1ns/1ps
`include "rtcal_cfg.svh"
module rtcal_core #(
	parameter logic [6:0] SLV_ADDR = `RTCAL_ADDR,
	parameter int         XT_HZ    = `RTCAL_XT_HZ,
	parameter int         ADJ_SECS = `RTCAL_ADJ_SECS
) (
	// clocks, reset, enable
	input  logic clk,
	input  logic clk_xtal,
	input  logic rstn,
	input  logic ce,
	// two-wire bus
	input  logic scl_i,
	input  logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// alarm interrupts, open drain
	output logic weekly_alarm_irq_n,
	output logic weekly_alarm_irq_n_oe,
	output logic daily_alarm_irq_n,
	output logic daily_alarm_irq_n_oe
);

if (XT_HZ < 256 || XT_HZ > 65000 || ADJ_SECS < 1 || ADJ_SECS > 15) begin : g_bad
	$error("rtcal_core: XT_HZ or ADJ_SECS out of range");
end

localparam logic [15:0] XT_TOP = 16'(XT_HZ - 1);
localparam logic [3:0]  S_LAST = 4'(ADJ_SECS - 1);

////////////////////////////////////////////////////////////////////////////////

function automatic logic [7:0] bcd_inc(input logic [7:0] v);
	return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
endfunction : bcd_inc

// writable bits per offset, unused bits read zero
function automatic logic [7:0] wmask(input logic [3:0] a);
	unique case (a)
		`RTCAL_HR, `RTCAL_DAY, `RTCAL_WHR, `RTCAL_DHR: return 8'h3F;
		`RTCAL_WDAY: return 8'h07;
		`RTCAL_MON: return 8'h9F;
		`RTCAL_YR, `RTCAL_CTL1, `RTCAL_CTL2: return 8'hFF;
		4'hD: return 8'h00;
		default: return 8'h7F;
	endcase
endfunction : wmask

// two-digit bcd year divisible by 4; year 00 counts only in the 2000s
function automatic logic leap(input logic [7:0] y, input logic cen);
	logic d4;
	d4 = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
	return d4 && !(y == 8'h00 && !cen);
endfunction : leap

function automatic logic [7:0] dim(input logic [4:0] m, input logic lp);
	unique case (m)
		5'h02: return lp ? 8'h29 : 8'h28;
		5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
		default: return 8'h31;
	endcase
endfunction : dim

////////////////////////////////////////////////////////////////////////////////

rtcal_pkg::rtcal_bus_t q;
rtcal_pkg::rtcal_bus_t n;
rtcal_pkg::rtcal_xt_t  x;
rtcal_pkg::rtcal_xt_t  m;
logic        scl_r;
logic        scl_f;
logic        sta;
logic        sto;
logic        tick;
logic        mb;
logic        roll;
logic        yr_wrap;
logic        lp;
logic        wr;
logic        wm;
logic        dmt;
logic [7:0]  dm;
logic [15:0] lim;

always_comb begin
	n = q;
	scl_r = q.scl_s2 & ~q.scl_p;
	scl_f = ~q.scl_s2 & q.scl_p;
	sta = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
	sto = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
	tick = q.tk_s2 ^ q.tk_p;
	wr = 1'b0;
	lp = leap(q.r[`RTCAL_YR], q.r[`RTCAL_MON][`RTCAL_CEN]);
	dm = dim(q.r[`RTCAL_MON][4:0], lp);
	mb = tick & (q.r[`RTCAL_SEC] == 8'h59);
	roll = mb & (q.r[`RTCAL_MIN] == 8'h59) & (q.r[`RTCAL_HR] == 8'h23);
	yr_wrap = roll & (q.r[`RTCAL_DAY] == dm) & (q.r[`RTCAL_MON][4:0] == 5'h12) & (q.r[`RTCAL_YR] == 8'h99);
	// pins and crossings: first stage read only by the second
	n.scl_s1 = scl_i;
	n.scl_s2 = q.scl_s1;
	n.scl_p = q.scl_s2;
	n.sda_s1 = sda_i;
	n.sda_s2 = q.sda_s1;
	n.sda_p = q.sda_s2;
	n.tk_s1 = x.tk;
	n.tk_s2 = q.tk_s1;
	n.tk_p = q.tk_s2;
	n.ak_s1 = x.ack;
	n.ak_s2 = q.ak_s1;
	// correction word held steady until the crystal side acks
	if (q.req == q.ak_s2 && q.hold != q.r[`RTCAL_ADJ][6:0]) begin
		n.hold = q.r[`RTCAL_ADJ][6:0];
		n.req = ~q.req;
	end

	// bcd time chain
	if (tick) begin
		n.r[`RTCAL_SEC] = bcd_inc(q.r[`RTCAL_SEC]);
	end
	if (mb) begin
		n.r[`RTCAL_SEC] = 8'h00;
		n.r[`RTCAL_MIN] = (q.r[`RTCAL_MIN] == 8'h59) ? 8'h00 : bcd_inc(q.r[`RTCAL_MIN]);
		if (q.r[`RTCAL_MIN] == 8'h59) begin
			n.r[`RTCAL_HR] = bcd_inc(q.r[`RTCAL_HR]);
		end
	end
	if (roll) begin
		n.r[`RTCAL_HR] = 8'h00;
		n.r[`RTCAL_WDAY] = (q.r[`RTCAL_WDAY] == 8'h06) ? 8'h00 : q.r[`RTCAL_WDAY] + 8'h01;
		n.r[`RTCAL_DAY] = bcd_inc(q.r[`RTCAL_DAY]);
		if (q.r[`RTCAL_DAY] == dm) begin
			n.r[`RTCAL_DAY] = `RTCAL_RST_DATE;
			n.r[`RTCAL_MON] = bcd_inc(q.r[`RTCAL_MON] & 8'h1F) | (q.r[`RTCAL_MON] & 8'h80);
			if (q.r[`RTCAL_MON][4:0] == 5'h12) begin
				n.r[`RTCAL_MON] = (q.r[`RTCAL_MON] & 8'h80) | `RTCAL_RST_DATE;
				n.r[`RTCAL_YR] = bcd_inc(q.r[`RTCAL_YR]);
			end
		end
	end
	if (yr_wrap) begin
		n.r[`RTCAL_YR] = 8'h00;
		n.r[`RTCAL_MON][`RTCAL_CEN] = ~q.r[`RTCAL_MON][`RTCAL_CEN];
	end

	// bus slave; the host write of a byte overrides the tick in that cycle
	if (sta) begin
		n.st = rtcal_pkg::ST_ADDR;
		n.cnt = 4'h0;
		n.oe = 1'b0;
	end else if (sto) begin
		n.st = rtcal_pkg::ST_IDLE;
		n.oe = 1'b0;
	end else if (q.st != rtcal_pkg::ST_IDLE && q.st != rtcal_pkg::ST_SKIP) begin
		if (scl_r) begin
			if (q.cnt != 4'h8) begin
				n.sh = {q.sh[6:0], q.sda_s2};
			end else begin
				n.mnak = q.sda_s2;
			end
			n.cnt = q.cnt + 4'h1;
		end else if (scl_f) begin
			if (q.cnt == 4'h8) begin
				n.oe = (q.st != rtcal_pkg::ST_RDAT);
				if (q.st == rtcal_pkg::ST_ADDR) begin
					if (q.sh[7:1] == SLV_ADDR) begin
						n.rw = q.sh[0];
					end else begin
						n.st = rtcal_pkg::ST_SKIP;
						n.oe = 1'b0;
					end
				end else if (q.st == rtcal_pkg::ST_PTR) begin
					n.ptr = q.sh[3:0];
				end else if (q.st == rtcal_pkg::ST_WDAT) begin
					wr = 1'b1;
					n.r[q.ptr] = q.sh & wmask(q.ptr);
					if (q.ptr == `RTCAL_CTL2) begin // flags: writing 0 clears, 1 keeps
						n.r[`RTCAL_CTL2][1:0] = q.sh[1:0] & q.r[`RTCAL_CTL2][1:0];
					end
					n.ptr = q.ptr + 4'h1;
				end
			end else if (q.cnt == 4'h9) begin
				n.cnt = 4'h0;
				n.oe = 1'b0;
				if (q.st == rtcal_pkg::ST_PTR) begin
					n.st = rtcal_pkg::ST_WDAT;
				end else if (q.st == rtcal_pkg::ST_ADDR && !q.rw) begin
					n.st = rtcal_pkg::ST_PTR;
				end else if (q.st == rtcal_pkg::ST_RDAT && q.mnak) begin
					n.st = rtcal_pkg::ST_SKIP;
				end else if (q.st != rtcal_pkg::ST_WDAT) begin
					n.st = rtcal_pkg::ST_RDAT;
					n.sh = q.r[q.ptr];
					n.ptr = q.ptr + 4'h1;
					n.oe = ~q.r[q.ptr][7];
				end
			end else if (q.st == rtcal_pkg::ST_RDAT) begin
				n.oe = ~q.sh[7];
			end
		end
	end

	// alarms compare the new minute; set wins over a host clear
	wm = mb & (n.r[`RTCAL_MIN] == q.r[`RTCAL_WMIN]) & (n.r[`RTCAL_HR] == q.r[`RTCAL_WHR])
		& q.r[`RTCAL_WWD][n.r[`RTCAL_WDAY][2:0]];
	dmt = mb & (n.r[`RTCAL_MIN] == q.r[`RTCAL_DMIN]) & (n.r[`RTCAL_HR] == q.r[`RTCAL_DHR]);
	if (wm) begin
		n.r[`RTCAL_CTL2][`RTCAL_WFLG] = 1'b1;
	end
	if (dmt) begin
		n.r[`RTCAL_CTL2][`RTCAL_DFLG] = 1'b1;
	end
	if (!n.r[`RTCAL_CTL1][`RTCAL_WEN]) begin
		n.r[`RTCAL_CTL2][`RTCAL_WFLG] = 1'b0;
	end
	if (!n.r[`RTCAL_CTL1][`RTCAL_DEN]) begin
		n.r[`RTCAL_CTL2][`RTCAL_DFLG] = 1'b0;
	end
end

always_ff @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		q <= '0;
		q.r[`RTCAL_DAY] <= `RTCAL_RST_DATE;
		q.r[`RTCAL_MON] <= `RTCAL_RST_DATE;
		// pins idle high; zeros here would fake an edge after reset
		q.scl_s1 <= 1'b1;
		q.scl_s2 <= 1'b1;
		q.scl_p  <= 1'b1;
		q.sda_s1 <= 1'b1;
		q.sda_s2 <= 1'b1;
		q.sda_p  <= 1'b1;
	end else if (ce) begin
		q <= n;
	end
end

assign sda_o = 1'b0;
assign sda_oe = q.oe;
assign weekly_alarm_irq_n = 1'b0;
assign daily_alarm_irq_n = 1'b0;
assign weekly_alarm_irq_n_oe = q.r[`RTCAL_CTL2][`RTCAL_WFLG];
assign daily_alarm_irq_n_oe = q.r[`RTCAL_CTL2][`RTCAL_DFLG];

////////////////////////////////////////////////////////////////////////////////
// crystal domain: free divider, trimmed once every ADJ_SECS seconds

always_comb begin
	m = x;
	m.rq_s1 = q.req;
	m.rq_s2 = x.rq_s1;
	m.ack = x.rq_s2;
	if (x.rq_s2 != x.ack) begin
		m.adj = q.hold;
	end
	lim = XT_TOP;
	if (x.s10 == S_LAST) begin
		lim = x.adj[`RTCAL_ADJ_DIR] ? XT_TOP - {10'h000, x.adj[5:0]} : XT_TOP + {10'h000, x.adj[5:0]};
	end
	// >= so a shortened period never overruns into a long wrap
	if (x.div >= lim) begin
		m.div = 16'h0000;
		m.tk = ~x.tk;
		m.s10 = (x.s10 == S_LAST) ? 4'h0 : x.s10 + 4'h1;
	end else begin
		m.div = x.div + 16'h0001;
	end
end

always_ff @(posedge clk_xtal or negedge rstn) begin
	if (!rstn) begin
		x <= '0;
	end else begin
		x <= m;
	end
end

////////////////////////////////////////////////////////////////////////////////

property p_sda_od;
	@(posedge clk) disable iff (!rstn) $rose(sda_oe) |-> !sda_o && $past(scl_f);
endproperty
a_sda_od: assert property (p_sda_od) else $error("data line driven outside a clock low");

property p_wr_take;
	@(posedge clk) disable iff (!rstn) ce && wr && q.ptr == `RTCAL_SEC |=> q.r[`RTCAL_SEC] == ($past(q.sh) & 8'h7F);
endproperty
a_wr_take: assert property (p_wr_take) else $error("seconds write not stored");

property p_feb;
	@(posedge clk) disable iff (!rstn) ce && roll && !wr && q.r[`RTCAL_MON][4:0] == 5'h02 && q.r[`RTCAL_DAY] == 8'h28
		|=> q.r[`RTCAL_DAY] == ($past(lp) ? 8'h29 : 8'h01);
endproperty
a_feb: assert property (p_feb) else $error("february end wrong");

property p_cen;
	@(posedge clk) disable iff (!rstn) ce && yr_wrap && !wr
		|=> q.r[`RTCAL_YR] == 8'h00 && q.r[`RTCAL_MON][`RTCAL_CEN] != $past(q.r[`RTCAL_MON][`RTCAL_CEN]);
endproperty
a_cen: assert property (p_cen) else $error("century bit not toggled");

property p_y00;
	@(posedge clk) disable iff (!rstn) q.r[`RTCAL_YR] == 8'h00 |-> lp == q.r[`RTCAL_MON][`RTCAL_CEN];
endproperty
a_y00: assert property (p_y00) else $error("year 00 leap wrong");

property p_wk;
	@(posedge clk) disable iff (!rstn) $rose(weekly_alarm_irq_n_oe) |-> q.r[`RTCAL_MIN] == q.r[`RTCAL_WMIN]
		&& q.r[`RTCAL_HR] == q.r[`RTCAL_WHR] && q.r[`RTCAL_WWD][q.r[`RTCAL_WDAY][2:0]];
endproperty
a_wk: assert property (p_wk) else $error("weekly alarm without match");

property p_dy;
	@(posedge clk) disable iff (!rstn) $rose(daily_alarm_irq_n_oe)
		|-> q.r[`RTCAL_MIN] == q.r[`RTCAL_DMIN] && q.r[`RTCAL_HR] == q.r[`RTCAL_DHR] && q.r[`RTCAL_CTL1][`RTCAL_DEN];
endproperty
a_dy: assert property (p_dy) else $error("daily alarm without match");

property p_clr;
	@(posedge clk) disable iff (!rstn) ce && wr && q.ptr == `RTCAL_CTL2 && !q.sh[`RTCAL_WFLG] && !wm
		|=> !weekly_alarm_irq_n_oe;
endproperty
a_clr: assert property (p_clr) else $error("weekly flag not cleared");

property p_addr;
	@(posedge clk) disable iff (!rstn) ce && scl_f && q.cnt == 4'h8 && q.st == rtcal_pkg::ST_ADDR
		&& q.sh[7:1] != SLV_ADDR |=> !sda_oe [*2];
endproperty
a_addr: assert property (p_addr) else $error("answered a foreign address");

property p_div;
	@(posedge clk_xtal) disable iff (!rstn) x.div < lim |=> x.tk == $past(x.tk) && x.div == $past(x.div) + 16'h0001;
endproperty
a_div: assert property (p_div) else $error("second tick off divider");

endmodule : rtcal_core

// file: verilog/rtcal_pkg.sv
package rtcal_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDAT, ST_RDAT, ST_SKIP} rtcal_st_t;

	// state on the core clock, clk
	typedef struct packed {
		rtcal_st_t        st;
		logic [3:0]       cnt;
		logic [7:0]       sh;
		logic [3:0]       ptr;
		logic             rw;
		logic             mnak;
		logic             oe;
		logic             scl_s1;
		logic             scl_s2;
		logic             scl_p;
		logic             sda_s1;
		logic             sda_s2;
		logic             sda_p;
		logic             tk_s1;
		logic             tk_s2;
		logic             tk_p;
		logic             ak_s1;
		logic             ak_s2;
		logic             req;
		logic [6:0]       hold;
		logic [15:0][7:0] r;
	} rtcal_bus_t;

	// state on the crystal clock
	typedef struct packed {
		logic        rq_s1;
		logic        rq_s2;
		logic        ack;
		logic [6:0]  adj;
		logic [15:0] div;
		logic [3:0]  s10;
		logic        tk;
	} rtcal_xt_t;
endpackage : rtcal_pkg
